// ==== rtl/iodr_pkg.sv ====
package iodr_pkg;

    // Register byte offsets
    localparam logic [7:0] IODR_CMD_OFS = 8'h00;
    localparam logic [7:0] IODR_DSC_OFS = 8'h04;
    localparam logic [7:0] IODR_DMA_OFS = 8'h08;
    localparam logic [7:0] IODR_CNT_OFS = 8'h0c;
    localparam logic [7:0] IODR_DIR_OFS = 8'h10;
    localparam logic [7:0] IODR_STS_OFS = 8'h14;
    localparam logic [7:0] IODR_PA_OFS = 8'h18;

    // Command register bit positions
    localparam int IODR_CMD_RETPOP = 0;
    localparam int IODR_CMD_DISINT = 1;
    localparam int IODR_CMD_ENINT = 2;
    localparam int IODR_CMD_DMA = 3;
    localparam int IODR_CMD_DDR = 4;
    localparam int IODR_CMD_PCM = 5;

    // Status register field positions
    localparam int IODR_STS_MODE = 0;
    localparam int IODR_STS_INTEN = 2;
    localparam int IODR_STS_BUSY = 3;
    localparam int IODR_STS_LEVEL = 4;
    localparam int IODR_STS_PA = 8;
    localparam int IODR_STS_DEPTH = 12;

    // Widths and sizes
    localparam int IODR_SC_W = 4;
    localparam int IODR_MA_W = 16;
    localparam int IODR_STK_N = 3;
    localparam int IODR_SYNC_W = 9;
    localparam logic [1:0] IODR_STK_TOP = 2'd2;

    // Reset values; active-low pins idle high in the synchroniser
    localparam logic [IODR_SYNC_W-1:0] IODR_SYNC_RST = 9'h019;
    localparam logic IODR_INTEN_RST = 1'b0;

    // Cycles for a cycle-steal peripheral's request to drop through the synchroniser
    localparam logic [1:0] IODR_SETTLE_CYC = 2'd2;

    typedef enum logic [1:0] {IODR_MODE_DMA, IODR_MODE_DDR, IODR_MODE_PCM} iodr_mode_t;

    typedef struct packed {
        logic bus_request;
        logic io_strobe;
        logic [IODR_SC_W-1:0] sc;
        logic last_word;
        logic mem_req;
        logic mem_output;
        logic [IODR_MA_W-1:0] mem_addr;
    } iodr_dma_bus_t;

    typedef struct packed {
        logic grant;
        logic [IODR_SC_W-1:0] pa;
        logic [1:0] level;
    } iodr_int_bus_t;

endpackage

// ==== rtl/iodr_dma_chan.sv ====
module iodr_dma_chan
    import iodr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Mode and synchronised pins
    input wire iodr_mode_t mode,
    input wire logic req,
    input wire logic grant,
    input wire logic mem_done,
    // Register loads
    input wire logic ld_sc,
    input wire logic ld_ma,
    input wire logic ld_cnt,
    input wire logic ld_dir,
    input wire logic [IODR_MA_W-1:0] wdata,
    // Register contents and status
    output logic [IODR_SC_W-1:0] sc_q,
    output logic [IODR_MA_W-1:0] ma_q,
    output logic [IODR_MA_W-1:0] cnt_q,
    output logic dir_q,
    output logic busy,
    // Bus side
    output iodr_dma_bus_t dma_bus
);

    typedef enum logic [2:0] {ST_IDLE, ST_ASK, ST_IO, ST_MEM, ST_UPD, ST_SETTLE} iodr_dma_st_t;

    iodr_dma_st_t st_q;
    logic pcm_q;
    logic [1:0] settle_q;
    logic take;

    assign take = req && (mode != IODR_MODE_DDR);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q <= ST_IDLE;
            pcm_q <= 1'b0;
            settle_q <= 2'd0;
        end
        else
        begin
            unique case (st_q)
                ST_IDLE:
                    if (take)
                    begin
                        st_q <= ST_ASK;
                        pcm_q <= (mode == IODR_MODE_PCM);
                    end
                ST_ASK:
                    if (grant)
                        st_q <= (pcm_q || !dir_q) ? ST_IO : ST_MEM;
                ST_IO:
                    st_q <= (pcm_q || dir_q) ? ST_UPD : ST_MEM;
                ST_MEM:
                    if (mem_done)
                        st_q <= dir_q ? ST_IO : ST_UPD;
                ST_UPD:
                begin
                    st_q <= ST_SETTLE;
                    settle_q <= 2'd0;
                end
                ST_SETTLE:
                    // Bus kept while the request stands, giving burst transfers
                    if (settle_q == IODR_SETTLE_CYC - 2'd1)
                    begin
                        if (take)
                        begin
                            pcm_q <= (mode == IODR_MODE_PCM);
                            st_q <= ((mode == IODR_MODE_PCM) || !dir_q) ? ST_IO : ST_MEM;
                        end
                        else
                            st_q <= ST_IDLE;
                    end
                    else
                        settle_q <= settle_q + 2'd1;
            endcase
        end
    end

    // Software loads win over the automatic update
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sc_q <= '0;
            ma_q <= '0;
            cnt_q <= '0;
            dir_q <= 1'b0;
        end
        else
        begin
            if (ld_sc)
                sc_q <= wdata[IODR_SC_W-1:0];
            if (ld_dir)
                dir_q <= wdata[0];
            if (ld_ma)
                ma_q <= wdata;
            else if (st_q == ST_UPD)
                ma_q <= ma_q + 16'h0001;
            if (ld_cnt)
                cnt_q <= wdata;
            else if (st_q == ST_UPD)
                cnt_q <= cnt_q - 16'h0001;
        end
    end

    assign busy = (st_q != ST_IDLE);

    always_comb
    begin
        dma_bus.bus_request = (st_q != ST_IDLE);
        dma_bus.io_strobe = (st_q == ST_IO);
        dma_bus.sc = sc_q;
        dma_bus.last_word = (st_q == ST_IO) && (cnt_q == '0);
        dma_bus.mem_req = (st_q == ST_MEM);
        dma_bus.mem_output = dir_q;
        dma_bus.mem_addr = ma_q;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_ONE_WORD: assert property (dma_bus.io_strobe |=> !dma_bus.io_strobe [*2])
        else $error("two io cycles too close");
    AST_COUNT_STEP: assert property ((st_q == ST_UPD && !ld_cnt && !ld_ma) |=>
        (cnt_q == $past(cnt_q) - 16'h0001) && (ma_q == $past(ma_q) + 16'h0001))
        else $error("address or count not stepped");
    AST_PCM_NO_MEM: assert property (pcm_q |-> !dma_bus.mem_req)
        else $error("memory cycle in pulse count mode");
    AST_BURST_HOLD: assert property ((st_q == ST_SETTLE && settle_q == IODR_SETTLE_CYC - 2'd1 && take) |=>
        dma_bus.bus_request && (st_q == ST_IO || st_q == ST_MEM))
        else $error("bus released while request held");
    COV_BURST: cover property (dma_bus.io_strobe ##[1:8] dma_bus.io_strobe);
    COV_PCM: cover property (pcm_q && dma_bus.io_strobe);

endmodule // iodr_dma_chan

// ==== rtl/iodr_io_ctrl.sv ====
// The placing of the registers and register access over AHB-Lite were left to the implementer.
module iodr_io_ctrl
    import iodr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Processor side
    input wire logic instr_fetch,
    // Peripheral pins
    input wire logic dma_request_n,
    input wire logic bus_grant,
    input wire logic mem_done,
    input wire logic [1:0] irq_n,
    input wire logic [IODR_SC_W-1:0] irq_sc,
    // Outputs to bus and processor
    output iodr_dma_bus_t dma_bus,
    output iodr_int_bus_t int_bus
);

    // Pin synchronisers
    logic [IODR_SYNC_W-1:0] sync_raw;
    logic [IODR_SYNC_W-1:0] sync_a_q;
    logic [IODR_SYNC_W-1:0] sync_q;

    assign sync_raw = {irq_sc, irq_n, mem_done, bus_grant, dma_request_n};

    genvar gi;
    generate
        for (gi = 0; gi < IODR_SYNC_W; gi++)
        begin : g_sync
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    sync_a_q[gi] <= IODR_SYNC_RST[gi];
                    sync_q[gi] <= IODR_SYNC_RST[gi];
                end
                else
                begin
                    sync_a_q[gi] <= sync_raw[gi];
                    sync_q[gi] <= sync_a_q[gi];
                end
            end
        end
    endgenerate

    logic dreq_s;
    logic grant_s;
    logic mdone_s;
    logic [1:0] irq_s;
    logic [IODR_SC_W-1:0] isc_s;

    assign dreq_s = !sync_q[0];
    assign grant_s = sync_q[1];
    assign mdone_s = sync_q[2];
    assign irq_s = ~sync_q[4:3];
    assign isc_s = sync_q[8:5];

    // AHB-Lite: writes with no wait, reads with one wait for a registered hrdata
    logic ap_take;
    logic dp_wr_q;
    logic dp_map_q;
    logic [7:0] dp_ofs_q;
    logic rd_wait_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;
    logic wr_en;

    assign ap_take = hsel && hready && htrans[1];
    assign hreadyout = !rd_wait_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_q <= 1'b0;
            dp_map_q <= 1'b0;
            dp_ofs_q <= 8'h00;
        end
        else if (hready)
        begin
            dp_wr_q <= ap_take && hwrite;
            dp_map_q <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
            dp_ofs_q <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rd_wait_q <= 1'b0;
        else if (rd_wait_q)
            rd_wait_q <= 1'b0;
        else if (hready)
            rd_wait_q <= ap_take && !hwrite;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h00000000;
        else if (rd_wait_q)
            hrdata_q <= rd_mux;
    end

    assign wr_en = dp_wr_q && dp_map_q;

    logic cmd_wr;
    logic pa_wr;
    assign cmd_wr = wr_en && (dp_ofs_q == IODR_CMD_OFS);
    assign pa_wr = wr_en && (dp_ofs_q == IODR_PA_OFS);

    // DMA selection, one encoded register
    iodr_mode_t mode_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mode_q <= IODR_MODE_DDR;
        else if (cmd_wr)
        begin
            // Several mode bits at once: the lowest one is taken
            if (hwdata[IODR_CMD_DMA])
                mode_q <= IODR_MODE_DMA;
            else if (hwdata[IODR_CMD_DDR])
                mode_q <= IODR_MODE_DDR;
            else if (hwdata[IODR_CMD_PCM])
                mode_q <= IODR_MODE_PCM;
        end
    end

    // DMA channel; it sees no interrupt state at all
    logic [IODR_SC_W-1:0] dsc_q;
    logic [IODR_MA_W-1:0] dma_q;
    logic [IODR_MA_W-1:0] cnt_q;
    logic dir_q;
    logic dma_busy;

    iodr_dma_chan u_chan (
        .hclk(hclk),
        .hresetn(hresetn),
        .mode(mode_q),
        .req(dreq_s),
        .grant(grant_s),
        .mem_done(mdone_s),
        .ld_sc(wr_en && (dp_ofs_q == IODR_DSC_OFS)),
        .ld_ma(wr_en && (dp_ofs_q == IODR_DMA_OFS)),
        .ld_cnt(wr_en && (dp_ofs_q == IODR_CNT_OFS)),
        .ld_dir(wr_en && (dp_ofs_q == IODR_DIR_OFS)),
        .wdata(hwdata[IODR_MA_W-1:0]),
        .sc_q(dsc_q),
        .ma_q(dma_q),
        .cnt_q(cnt_q),
        .dir_q(dir_q),
        .busy(dma_busy),
        .dma_bus(dma_bus)
    );

    // Interrupt grant enable; disable wins if both bits are written
    logic int_en_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            int_en_q <= IODR_INTEN_RST;
        else if (cmd_wr && hwdata[IODR_CMD_DISINT])
            int_en_q <= 1'b0;
        else if (cmd_wr && hwdata[IODR_CMD_ENINT])
            int_en_q <= 1'b1;
    end

    // Peripheral address and priority stack; entry 0 is the base level
    logic [IODR_SC_W-1:0] pa_stk_q [IODR_STK_N];
    logic [1:0] prio_stk_q [IODR_STK_N];
    logic [1:0] depth_q;
    logic [1:0] pend_lvl;
    logic [1:0] prio_cur;
    logic [IODR_SC_W-1:0] pa_cur;
    logic ret_pop;
    logic do_pop;
    logic grant_now;
    logic grant_q;
    // Entry a pop returns to; only meaningful while depth is above zero
    logic [IODR_SC_W-1:0] pa_below;

    assign prio_cur = prio_stk_q[depth_q];
    assign pa_cur = pa_stk_q[depth_q];
    assign pa_below = pa_stk_q[depth_q - 2'd1];
    assign pend_lvl = irq_s[1] ? 2'd2 : (irq_s[0] ? 2'd1 : 2'd0);
    assign ret_pop = cmd_wr && hwdata[IODR_CMD_RETPOP];
    assign do_pop = ret_pop && (depth_q != 2'd0);
    // Level-held request is granted again after a pop with no data cycle
    assign grant_now = instr_fetch && int_en_q && !ret_pop && (pend_lvl > prio_cur)
        && (depth_q != IODR_STK_TOP);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            depth_q <= 2'd0;
            for (int i = 0; i < IODR_STK_N; i++)
            begin
                pa_stk_q[i] <= '0;
                prio_stk_q[i] <= 2'd0;
            end
        end
        else if (do_pop)
            depth_q <= depth_q - 2'd1;
        else if (grant_now)
        begin
            depth_q <= depth_q + 2'd1;
            pa_stk_q[depth_q + 2'd1] <= isc_s;
            prio_stk_q[depth_q + 2'd1] <= pend_lvl;
        end
        else if (pa_wr)
            pa_stk_q[depth_q] <= hwdata[IODR_SC_W-1:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            grant_q <= 1'b0;
        else
            grant_q <= grant_now;
    end

    always_comb
    begin
        int_bus.grant = grant_q;
        int_bus.pa = pa_cur;
        int_bus.level = prio_cur;
    end

    // Register read mux; unmapped reads return zero
    always_comb
    begin
        rd_mux = 32'h00000000;
        if (dp_map_q)
        begin
            unique case (dp_ofs_q)
                IODR_DSC_OFS: rd_mux[IODR_SC_W-1:0] = dsc_q;
                IODR_DMA_OFS: rd_mux[IODR_MA_W-1:0] = dma_q;
                IODR_CNT_OFS: rd_mux[IODR_MA_W-1:0] = cnt_q;
                IODR_DIR_OFS: rd_mux[0] = dir_q;
                IODR_PA_OFS: rd_mux[IODR_SC_W-1:0] = pa_cur;
                IODR_STS_OFS:
                begin
                    rd_mux[IODR_STS_MODE +: 2] = mode_q;
                    rd_mux[IODR_STS_INTEN] = int_en_q;
                    rd_mux[IODR_STS_BUSY] = dma_busy;
                    rd_mux[IODR_STS_LEVEL +: 2] = prio_cur;
                    rd_mux[IODR_STS_PA +: IODR_SC_W] = pa_cur;
                    rd_mux[IODR_STS_DEPTH +: 2] = depth_q;
                end
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_NO_GRANT_DISABLED: assert property (!int_en_q |=> !grant_q)
        else $error("interrupt granted while disabled");
    AST_POP_LOWERS: assert property (do_pop |=> (depth_q == $past(depth_q) - 2'd1)
        && (prio_cur < $past(prio_cur)))
        else $error("pop did not lower priority");
    AST_POP_DISABLED: assert property ((do_pop && !int_en_q) |=> depth_q != $past(depth_q))
        else $error("pop blocked while interrupts disabled");
    AST_GRANT_RAISES: assert property (grant_q |-> (prio_cur > $past(prio_cur))
        && (pa_cur == $past(isc_s)))
        else $error("grant without push of select code");
    AST_DDR_IGNORE: assert property ((mode_q == IODR_MODE_DDR && !dma_busy) |=> !dma_bus.bus_request)
        else $error("request taken in disabled state");
    AST_PCM_CMD: assert property ((cmd_wr && hwdata[IODR_CMD_PCM] && !hwdata[IODR_CMD_DMA]
        && !hwdata[IODR_CMD_DDR]) |=> mode_q == IODR_MODE_PCM)
        else $error("pulse count command not taken");
    AST_READ_WAIT: assert property ((ap_take && !hwrite && !rd_wait_q) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    // Commands act on the next edge; nothing else moves the mode, and only commands and instruction fetches move the interrupt depth and enable
    AST_WRITE_NOWAIT: assert property ((ap_take && hwrite && !rd_wait_q) |=> hreadyout)
        else $error("write data phase stalled");
    AST_DMA_CMD: assert property ((cmd_wr && hwdata[IODR_CMD_DMA]) |=> mode_q == IODR_MODE_DMA)
        else $error("dma mode command not taken");
    AST_DDR_CMD: assert property ((cmd_wr && hwdata[IODR_CMD_DDR] && !hwdata[IODR_CMD_DMA])
        |=> mode_q == IODR_MODE_DDR)
        else $error("disable data request command not taken");
    AST_MODE_HOLD: assert property (!cmd_wr |=> $stable(mode_q))
        else $error("dma selection changed without command");
    AST_EN_CMD: assert property ((cmd_wr && hwdata[IODR_CMD_ENINT] && !hwdata[IODR_CMD_DISINT])
        |=> int_en_q)
        else $error("interrupt enable not taken");
    AST_DIS_CMD: assert property ((cmd_wr && hwdata[IODR_CMD_DISINT]) |=> !int_en_q)
        else $error("interrupt disable not taken");
    AST_GRANT_ON_FETCH: assert property (grant_q |-> $past(instr_fetch) && !$past(ret_pop))
        else $error("grant without instruction fetch");
    AST_INT_APART: assert property ((!cmd_wr && !instr_fetch) |=> $stable(depth_q)
        && $stable(int_en_q))
        else $error("interrupt state moved by dma activity");
    AST_GRANT_SAVES_PA: assert property (grant_q |-> pa_below == $past(pa_cur))
        else $error("pre-interrupt address not kept below top");
    AST_POP_RESTORES_PA: assert property (do_pop |=> pa_cur == $past(pa_below))
        else $error("pop did not restore the address");
    COV_GRANT: cover property (grant_q);
    COV_POP: cover property (do_pop ##[1:20] grant_q);
    COV_DDR_REQ: cover property (mode_q == IODR_MODE_DDR && dreq_s && !dma_busy);

endmodule // iodr_io_ctrl

// ==== dv/iodr_periph_model.sv ====
module iodr_periph_model
    import iodr_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bench control
    input wire logic go,
    input wire logic burst,
    input wire logic [7:0] words,
    // Controller side
    input wire iodr_dma_bus_t dma_bus,
    output logic dma_request_n,
    output logic bus_grant,
    output logic mem_done
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] rem_q;

    // Only this card drives the line; released it sits at the pull-up level
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dma_request_n <= 1'b1;
            rem_q <= 8'h00;
        end
        else if (!go)
        begin
            dma_request_n <= 1'b1;
            rem_q <= words;
        end
        else if (dma_bus.io_strobe)
        begin
            rem_q <= rem_q - 8'h01;
            // Dropped in the strobe cycle so the synchroniser clears before settle ends
            if (!burst || rem_q == 8'h01)
                dma_request_n <= 1'b1;
        end
        else if (rem_q != 8'h00 && !dma_bus.bus_request)
            dma_request_n <= 1'b0;
    end

    // Arbiter and memory answer one cycle late
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_grant <= 1'b0;
            mem_done <= 1'b0;
        end
        else
        begin
            bus_grant <= dma_bus.bus_request;
            mem_done <= dma_bus.mem_req;
        end
    end
endmodule // iodr_periph_model

// ==== dv/test_io_dma_and_interrupt_return.sv ====
module test_io_dma_and_interrupt_return
    import iodr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [7:0] a;
        logic [31:0] w;
        logic [31:0] e;
    } iodr_row_t;

    logic hclk, hresetn, hsel, hwrite, instr_fetch, go, burst;
    logic hreadyout, hresp, dma_request_n, bus_grant, mem_done;
    logic br_q = 1'b0;
    logic mr_q = 1'b0;
    logic out_seen;
    logic [1:0] htrans, irq_n;
    logic [2:0] hsize;
    logic [3:0] irq_sc, sc_seen;
    logic [7:0] words;
    logic [15:0] ma_seen;
    logic [31:0] haddr, hwdata, hrdata, rd;
    iodr_dma_bus_t dma_bus;
    iodr_int_bus_t int_bus;
    int fail_count = 0;
    int check_count = 0;
    int n[5] = '{default: 0};
    int s[5];
    iodr_row_t rows[7] = '{
        '{IODR_DSC_OFS, 32'hffff_fff3, 32'h3}, '{IODR_DMA_OFS, 32'hffff_0100, 32'h100},
        '{IODR_CNT_OFS, 32'h2, 32'h2}, '{IODR_DIR_OFS, 32'hffff_fffe, 32'h0},
        '{IODR_PA_OFS, 32'h16, 32'h6}, '{8'h1c, 32'hffff_ffff, 32'h0}, '{IODR_CMD_OFS, 32'h0, 32'h0}};

    iodr_io_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .instr_fetch(instr_fetch), .dma_request_n(dma_request_n),
        .bus_grant(bus_grant), .mem_done(mem_done), .irq_n(irq_n), .irq_sc(irq_sc),
        .dma_bus(dma_bus), .int_bus(int_bus));

    iodr_periph_model card (.hclk(hclk), .hresetn(hresetn), .go(go), .burst(burst), .words(words),
        .dma_bus(dma_bus), .dma_request_n(dma_request_n), .bus_grant(bus_grant), .mem_done(mem_done));

    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    // Event counts: bus takes, strobes, last words, memory cycles, grants
    always @(posedge hclk)
    begin
        br_q <= dma_bus.bus_request;
        mr_q <= dma_bus.mem_req;
        n[0] += 32'(dma_bus.bus_request && !br_q);
        n[1] += 32'(dma_bus.io_strobe);
        n[2] += 32'(dma_bus.io_strobe && dma_bus.last_word);
        n[3] += 32'(dma_bus.mem_req && !mr_q);
        n[4] += 32'(int_bus.grant);
        if (dma_bus.io_strobe)
            sc_seen <= dma_bus.sc;
        if (dma_bus.mem_req)
            out_seen <= dma_bus.mem_output;
        if (dma_bus.mem_req)
            ma_seen <= dma_bus.mem_addr;
    end

    task automatic test_done();
        $display("Checks made %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] dl(input int i);
        return 32'(n[i] - s[i]);
    endfunction

    // Ready and read data are taken at the rising edge, before the slave updates
    task automatic wait_rdy();
        do
            @(posedge hclk);
        while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        @(negedge hclk);
    endtask

    // Card reloads its word count only while go is low
    task automatic start(input logic b, input logic [7:0] w);
        @(posedge hclk);
        go <= 1'b0;
        burst <= b;
        words <= w;
        repeat (2) @(posedge hclk);
        s = n;
        go <= 1'b1;
    endtask

    task automatic dma_wait(input int t);
        for (int i = 0; i < 2000 && !(dl(1) == 32'(t) && dma_bus.bus_request === 1'b0); i++)
            @(negedge hclk);
        repeat (4) @(negedge hclk);
        chk(dl(1), 32'(t));
    endtask

    task automatic fetch();
        @(posedge hclk);
        instr_fetch <= 1'b1;
        @(posedge hclk);
        instr_fetch <= 1'b0;
        @(negedge hclk);
    endtask

    task automatic irq(input logic [1:0] v, input logic [3:0] c);
        @(posedge hclk);
        irq_n <= v;
        irq_sc <= c;
        repeat (4) @(posedge hclk);
        fetch();
    endtask

    initial
    begin
        repeat (40000) @(posedge hclk);
        fail_count++;
        test_done();
    end

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        instr_fetch = 1'b0;
        irq_n = 2'b11;
        irq_sc = 4'h0;
        go = 1'b0;
        burst = 1'b0;
        words = 8'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk(32'(dma_bus), 32'h0);
        chk(32'({hresp, hreadyout}), 32'h1);
        ahb(1'b0, IODR_STS_OFS, 32'h0);
        chk(rd, 32'h1);
        foreach (rows[i])
        begin
            ahb(1'b1, rows[i].a, rows[i].w);
            ahb(1'b0, rows[i].a, 32'h0);
            chk(rd, rows[i].e);
        end
        // Request held low in the power-up mode must be ignored
        start(1'b0, 8'h3);
        repeat (30) @(posedge hclk);
        chk(dl(0), 32'h0);
        ahb(1'b1, IODR_CMD_OFS, 32'h8);
        dma_wait(3);
        chk(dl(0), 32'h3);
        chk(dl(3), 32'h3);
        chk(dl(2), 32'h1);
        chk(32'(sc_seen), 32'h3);
        chk(32'(ma_seen), 32'h102);
        ahb(1'b0, IODR_DMA_OFS, 32'h0);
        chk(rd, 32'h103);
        ahb(1'b0, IODR_CNT_OFS, 32'h0);
        chk(rd, 32'hffff);
        ahb(1'b1, IODR_DIR_OFS, 32'h1);
        ahb(1'b1, IODR_CNT_OFS, 32'h1);
        start(1'b1, 8'h2);
        dma_wait(2);
        chk(dl(0), 32'h1);
        chk(dl(3), 32'h2);
        chk(dl(2), 32'h1);
        chk(32'(out_seen), 32'h1);
        ahb(1'b1, IODR_CMD_OFS, 32'h20);
        ahb(1'b1, IODR_CNT_OFS, 32'h5);
        start(1'b0, 8'h2);
        dma_wait(2);
        chk(dl(3), 32'h0);
        chk(dl(0), 32'h2);
        ahb(1'b0, IODR_CNT_OFS, 32'h0);
        chk(rd, 32'h3);
        @(posedge hclk);
        go <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            ahb(1'b1, IODR_CMD_OFS, 32'h8 << i);
            ahb(1'b0, IODR_STS_OFS, 32'h0);
            chk(rd & 32'h3, 32'(i));
        end
        ahb(1'b1, IODR_CMD_OFS, 32'h4);
        irq(2'b10, 4'h5);
        chk(32'(int_bus), 32'h55);
        irq(2'b01, 4'h9);
        chk(32'(int_bus), 32'h66);
        ahb(1'b1, IODR_CMD_OFS, 32'h2);
        ahb(1'b1, IODR_CMD_OFS, 32'h1);
        chk(32'(int_bus), 32'h15);
        fetch();
        chk(32'(int_bus), 32'h15);
        ahb(1'b1, IODR_CMD_OFS, 32'h4);
        fetch();
        chk(32'(int_bus), 32'h66);
        @(posedge hclk);
        irq_n <= 2'b11;
        ahb(1'b1, IODR_CMD_OFS, 32'h1);
        ahb(1'b1, IODR_CMD_OFS, 32'h1);
        chk(32'(int_bus), 32'h18);
        test_done();
    end
endmodule // test_io_dma_and_interrupt_return
